// >>> cie_pkg.sv
// Package: constants and types for the clear instruction executor
package cie_pkg;
  localparam int INSTR_W = 16;
  localparam int ADDR_W = 8;
  localparam int BANK_W = 4;
  localparam int DATA_W = 8;
  localparam int WATCHDOG_W = 16;
  localparam int PSC_W = 16;
  localparam logic [6:0] CLR_OPC = 7'h35;        // Upper seven bits 0110 101
  localparam int CLR_OPC_LSB = 9;
  localparam int BANK_BIT = 8;
  localparam logic [15:0] WATCHDOG_OPC = 16'h0004; // Whole word 0000 0000 0000 0100
  localparam logic [7:0] IDX_LIMIT = 8'h5F;      // Indexed offset applies at or below this
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;   // Access bank low part ends below this
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_ZERO = 16'h0000;
  localparam logic [PSC_W-1:0] PSC_ZERO = 16'h0000;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;

  typedef enum logic [1:0] {
    Q_DECODE = 2'b00,
    Q_READ = 2'b01,
    Q_PROCESS = 2'b10,
    Q_WRITE = 2'b11
  } cie_phase_e;

  // Data memory write request
  typedef struct packed {
    logic we;
    logic [BANK_W+ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cie_wr_s;

  // Status flag update
  typedef struct packed {
    logic set_zero;
    logic set_timeout;
    logic set_powerdown;
    logic clr_watchdog;
  } cie_stat_s;
endpackage

// >>> cie_addr_calc.sv
// Address former for the register-clear instruction
`timescale 1ns/1ns
`default_nettype none
module cie_addr_calc
  import cie_pkg::*;
(
  input wire logic [ADDR_W-1:0] reg_field,
  input wire logic bank_bit,
  input wire logic ext_en,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic [ADDR_W-1:0] index_base,
  output logic [BANK_W+ADDR_W-1:0] full_addr
);
  // Bank choice and indexed literal offset mode
  always_comb begin
    if (bank_bit) begin
      full_addr = {bank_select_reg, reg_field};
    end else if (ext_en && reg_field <= IDX_LIMIT) begin
      full_addr = {BANK_RST, index_base} + {BANK_RST, reg_field};
    end else if (reg_field < ACCESS_SPLIT) begin
      full_addr = {BANK_RST, reg_field};
    end else begin
      full_addr = {ACCESS_HI_BANK, reg_field};
    end
  end
endmodule // cie_addr_calc
`default_nettype wire

// >>> cie_exec.sv
// Top: executes the register-clear and watchdog-clear instructions
// Function
// - Register-clear opcode writes zero to addressed register and sets zero flag.
// - Bank bit 0 selects access bank; 1 uses bank select register.
// - Bank bit 0 with extended set uses indexed offset when field at most 95.
// - Watchdog-clear zeroes counter and postscaler, sets timeout and powerdown flags.
`timescale 1ns/1ns
`default_nettype none
module cie_exec
  import cie_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire logic [cie_pkg::INSTR_W-1:0] INSTR_WORD,
  input wire logic EXT_EN,
  input wire logic [cie_pkg::BANK_W-1:0] BANK_SELECT_REG,
  input wire logic [cie_pkg::ADDR_W-1:0] INDEX_BASE,
  output logic INSTR_READY,
  output logic [1:0] PHASE,
  output cie_pkg::cie_wr_s MEM_WR,
  output cie_pkg::cie_stat_s STAT_UPD
);
  import cie_pkg::*;

  logic rst_meta;
  logic rst_sync;
  cie_phase_e phase;
  cie_phase_e next_phase;
  logic [INSTR_W-1:0] instr;
  logic [INSTR_W-1:0] next_instr;
  logic active;
  logic next_active;
  cie_wr_s wr;
  cie_wr_s next_wr;
  cie_stat_s stat;
  cie_stat_s next_stat;
  logic [BANK_W+ADDR_W-1:0] calc_addr;
  logic is_clr;
  logic is_watchdog;

  // Reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Opcode decode
  function automatic logic dec_clr(input logic [INSTR_W-1:0] w);
    dec_clr = (w[INSTR_W-1:CLR_OPC_LSB] == CLR_OPC);
  endfunction

  assign is_clr = dec_clr(instr);
  assign is_watchdog = (instr == WATCHDOG_OPC);

  cie_addr_calc u_addr (
    .reg_field(instr[ADDR_W-1:0]),
    .bank_bit(instr[BANK_BIT]),
    .ext_en(EXT_EN),
    .bank_select_reg(BANK_SELECT_REG),
    .index_base(INDEX_BASE),
    .full_addr(calc_addr)
  );

  // New word taken only at the decode phase
  assign INSTR_READY = (phase == Q_DECODE);
  assign PHASE = phase;
  assign MEM_WR = wr;
  assign STAT_UPD = stat;

  // Four-phase sequence and write/flag outputs
  always_comb begin
    next_phase = phase;
    next_instr = instr;
    next_active = active;
    next_wr = '0;
    next_stat = '0;
    unique case (phase)
      Q_DECODE: begin
        next_phase = Q_READ;
        next_active = INSTR_VALID;
        if (INSTR_VALID) begin
          next_instr = INSTR_WORD;
        end
      end
      Q_READ: begin
        next_phase = Q_PROCESS;
      end
      Q_PROCESS: begin
        next_phase = Q_WRITE;
        if (active && is_clr) begin
          next_wr.we = 1'b1;
          next_wr.addr = calc_addr;
          next_wr.data = DATA_ZERO;
          next_stat.set_zero = 1'b1;
        end
        if (active && is_watchdog) begin
          next_stat.clr_watchdog = 1'b1;
          next_stat.set_timeout = 1'b1;
          next_stat.set_powerdown = 1'b1;
        end
      end
      Q_WRITE: begin
        next_phase = Q_DECODE;
        next_active = 1'b0;
      end
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge CLK_SYS or negedge rst_sync) begin
    if (!rst_sync) begin
      phase <= Q_DECODE;
      instr <= '0;
      active <= 1'b0;
      wr <= '0;
      stat <= '0;
    end else begin
      phase <= next_phase;
      instr <= next_instr;
      active <= next_active;
      wr <= next_wr;
      stat <= next_stat;
    end
  end

  // Watchdog model: counter and postscaler cleared by the pulse
  logic [WATCHDOG_W-1:0] watchdog_cnt;
  logic [PSC_W-1:0] psc_cnt;
  logic [WATCHDOG_W-1:0] next_watchdog_cnt;
  logic [PSC_W-1:0] next_psc_cnt;
  always_comb begin
    next_psc_cnt = psc_cnt + PSC_W'(1'b1);
    next_watchdog_cnt = (psc_cnt == '1) ? watchdog_cnt + WATCHDOG_W'(1'b1) : watchdog_cnt;
    if (stat.clr_watchdog) begin
      next_psc_cnt = PSC_ZERO;
      next_watchdog_cnt = WATCHDOG_ZERO;
    end
  end

  // Watchdog counter registers
  always_ff @(posedge CLK_SYS or negedge rst_sync) begin
    if (!rst_sync) begin
      watchdog_cnt <= WATCHDOG_ZERO;
      psc_cnt <= PSC_ZERO;
    end else begin
      watchdog_cnt <= next_watchdog_cnt;
      psc_cnt <= next_psc_cnt;
    end
  end

  // Checks look one edge after the process phase, where the registered pulses stand
  // Checks on the register-clear path
  a_clr_writes_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_clr) |=> (wr.we && wr.data == DATA_ZERO && stat.set_zero))
    else $error("clear did not write zero");
  a_bank_select: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_clr && instr[BANK_BIT])
      |=> (wr.addr == {$past(BANK_SELECT_REG), $past(instr[ADDR_W-1:0])}))
    else $error("bank select not used");
  a_access_low: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_clr && !instr[BANK_BIT] && !EXT_EN && instr[ADDR_W-1:0] < ACCESS_SPLIT)
      |=> (wr.addr[BANK_W+ADDR_W-1:ADDR_W] == BANK_RST))
    else $error("access bank wrong");
  a_hi_bank: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_clr && !instr[BANK_BIT] && instr[ADDR_W-1:0] >= ACCESS_SPLIT)
      |=> (wr.addr == {ACCESS_HI_BANK, $past(instr[ADDR_W-1:0])}))
    else $error("upper access bank wrong");
  a_indexed_mode: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_clr && !instr[BANK_BIT] && EXT_EN && instr[ADDR_W-1:0] <= IDX_LIMIT)
      |=> (wr.addr == ({BANK_RST, $past(INDEX_BASE)} + {BANK_RST, $past(instr[ADDR_W-1:0])})))
    else $error("indexed offset wrong");
  a_plain_low: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_clr && !instr[BANK_BIT] && !EXT_EN && instr[ADDR_W-1:0] <= IDX_LIMIT)
      |=> (wr.addr == {BANK_RST, $past(instr[ADDR_W-1:0])}))
    else $error("offset used without extended set");
  a_zero_paired: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (wr.we == stat.set_zero))
    else $error("zero flag and write apart");
  a_no_spurious: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (stat.set_zero || wr.we) |-> $past(is_clr && active))
    else $error("spurious clear");

  // Checks on the watchdog-clear path and on words with no effect
  a_watchdog_flags: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && active && is_watchdog)
      |=> (stat.set_timeout && stat.set_powerdown && stat.clr_watchdog)
      ##1 (watchdog_cnt == WATCHDOG_ZERO && psc_cnt == PSC_ZERO))
    else $error("watchdog clear failed");
  a_watchdog_only: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    stat.clr_watchdog |-> $past(is_watchdog && active))
    else $error("spurious watchdog clear");
  a_noop_quiet: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase == Q_PROCESS && !(active && (is_clr || is_watchdog)))
      |=> (!wr.we && stat == '0))
    else $error("no-op word had an effect");

  // Checks on the four-phase sequence; the first edge after release still holds reset
  a_phase_cycle: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (rst_sync && phase == Q_DECODE) |=> (phase == Q_READ) ##1 (phase == Q_PROCESS) ##1 (phase == Q_WRITE) ##1 (phase == Q_DECODE))
    else $error("phase order broken");
  a_word_taken: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (rst_sync && phase == Q_DECODE) |=> (active == $past(INSTR_VALID)))
    else $error("valid not taken at decode");
  a_word_held: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (phase != Q_DECODE) |=> (instr == $past(instr)))
    else $error("word changed outside decode");
  a_write_in_q4: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    wr.we |-> (phase == Q_WRITE))
    else $error("write outside last phase");
  a_flags_in_q4: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (stat != '0) |-> (phase == Q_WRITE))
    else $error("flag pulse outside last phase");
  a_pulse_once: assert property (@(posedge CLK_SYS) disable iff (!rst_sync)
    (wr.we || stat != '0) |=> (!wr.we && stat == '0))
    else $error("pulse longer than one cycle");
endmodule // cie_exec
`default_nettype wire

// >>> cie_fetch_model.sv
// Fetch path model: offers instruction words to the executor
`timescale 1ns/1ns
`default_nettype none
module cie_fetch_model
  import cie_pkg::*;
(
  input wire logic clk,
  input wire logic run,
  input wire logic ready,
  output logic valid,
  output logic [INSTR_W-1:0] word
);
  logic taken;

  // Mix of clear, watchdog and unrelated words, with field boundaries
  function automatic logic [INSTR_W-1:0] pick();
    logic [7:0] f;
    f = ($urandom_range(2) == 0) ? 8'h5F + 8'($urandom_range(1)) : 8'($urandom);
    case ($urandom_range(3))
      0: pick = WATCHDOG_OPC;
      1: pick = 16'($urandom);
      default: pick = {CLR_OPC, 1'($urandom), f};
    endcase
  endfunction

  initial begin
    valid = 1'b0;
    word = 16'h0000;
    taken = 1'b0;
  end

  // A word is held until a decode edge takes it
  always @(posedge clk) taken <= valid && ready;

  // Slow or prompt offers; with run low the bus never repeats the old word
  always @(negedge clk) begin
    if (!valid || taken) begin
      valid <= run && ($urandom_range(3) != 0);
      word <= run ? pick() : ~word;
    end
  end
endmodule // cie_fetch_model
`default_nettype wire

// >>> tb.sv
// Testbench for the clear instruction executor
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cie_pkg::*;
  logic clk_sys, rstn, instr_valid, ext_en, run, instr_ready, armed;
  logic [INSTR_W-1:0] instr_word;
  logic [BANK_W-1:0] bank_sel;
  logic [ADDR_W-1:0] index_base, f;
  logic [1:0] phase, last_phase;
  cie_wr_s mem_wr, exp_wr;
  cie_stat_s stat_upd, exp_stat;
  int err_count, checks_done;

  cie_exec cie_exec_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .INSTR_VALID(instr_valid),
    .INSTR_WORD(instr_word), .EXT_EN(ext_en), .BANK_SELECT_REG(bank_sel),
    .INDEX_BASE(index_base), .INSTR_READY(instr_ready), .PHASE(phase),
    .MEM_WR(mem_wr), .STAT_UPD(stat_upd));
  cie_fetch_model cie_fetch_model_inst (.clk(clk_sys), .run(run), .ready(instr_ready),
    .valid(instr_valid), .word(instr_word));

  task automatic check(string what, logic [31:0] exp_v, logic [31:0] got);
    checks_done++;
    if (got !== exp_v) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Reference model: expected result of the word taken at a decode edge
  always @(posedge clk_sys) begin
    if (!armed) begin
      exp_wr = '0;
      exp_stat = '0;
    end else if (phase == 2'd0) begin
      exp_wr = '0;
      exp_stat = '0;
      f = instr_word[7:0];
      if (instr_valid && instr_word[15:9] == CLR_OPC) begin
        exp_wr.we = 1'b1;
        exp_stat.set_zero = 1'b1;
        if (instr_word[8]) exp_wr.addr = {bank_sel, f};
        else if (ext_en && f <= 8'h5F) exp_wr.addr = 12'(index_base) + 12'(f);
        else if (f < 8'h60) exp_wr.addr = {4'h0, f};
        else exp_wr.addr = {4'hF, f};
      end else if (instr_valid && instr_word == WATCHDOG_OPC) exp_stat = 4'b0111;
    end
  end

  // Compare outputs at every phase; new operands only after a result
  always @(negedge clk_sys) begin
    if (armed) begin
      check("phase", 32'(2'(last_phase + 2'd1)), 32'(phase));
      check("ready", 32'(phase == 2'd0), 32'(instr_ready));
      if (phase == 2'd3) begin
        check("write enable", 32'(exp_wr.we), 32'(mem_wr.we));
        if (exp_wr.we) check("write", 32'(exp_wr), 32'(mem_wr));
        check("status", 32'(exp_stat), 32'(stat_upd));
      end else begin
        check("idle write", 32'h0, 32'(mem_wr.we));
        check("idle status", 32'h0, 32'(stat_upd));
      end
    end
    last_phase = phase;
    if (phase == 2'd3) begin
      ext_en <= 1'($urandom);
      bank_sel <= 4'($urandom);
      index_base <= 8'($urandom);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Two runs, the second after a reset in mid-stream
  initial begin
    {rstn, armed, run, ext_en, bank_sel, index_base, last_phase} = '0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(32'h5092801E));
    for (int r = 0; r < 2; r++) begin
      armed = 1'b0;
      run = 1'b0;
      rstn = 1'b0;
      repeat (16) @(negedge clk_sys);
      check("reset state", 32'h1, 32'({phase, instr_ready, mem_wr, stat_upd} == 28'h2000000));
      rstn = 1'b1;
      repeat (8) @(negedge clk_sys);
      @(negedge clk_sys iff phase === 2'd3);
      armed = 1'b1;
      run = 1'b1;
      repeat (800) @(negedge clk_sys);
    end
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #250000;
    err_count++;
    summarize();
  end
endmodule // tb
`default_nettype wire
